// file: design/exc_unit.sv
`timescale 1ns/1ns
`include "exc_unit_params.svh"
module exc_unit #(
    parameter int STACK_IDX_W = 7
) (
    // Clock, reset, clock enable.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Register bus.
    input wire exc_unit_pkg::apb_req_t apb_req,
    output exc_unit_pkg::apb_rsp_t apb_rsp,
    // Instruction boundary report from the pipeline.
    input wire logic insn_done,
    input wire logic [1:0] insn_len,
    input wire logic is_call,
    input wire logic is_return,
    input wire logic is_dbranch,
    input wire logic is_trap,
    input wire logic [31:0] trap_entry,
    input wire logic [31:0] ret_pc,
    input wire logic [31:0] delay_pc,
    input wire logic in_delay_slot,
    input wire logic [1:0] branch_len,
    input wire logic range_err,
    input wire logic priv_err,
    input wire logic sw_wr,
    input wire logic [31:0] sw_wdata,
    // Memory access and stack frame checks.
    input wire logic mem_req,
    input wire logic addr_zero,
    input wire logic frame_restructure,
    input wire logic [31:0] frame_top,
    // Asynchronous conditions.
    input wire logic xovf_event,
    input wire logic parity_err,
    input wire logic [1:0] parity_area,
    input wire logic int_ext,
    input wire logic int_timer,
    input wire logic int_io_line_three,
    input wire logic reset_pin_n,
    input wire logic watchdog_overrun,
    // Results towards pipeline and register stack.
    output logic busy_r,
    output logic pc_load_r,
    output logic [31:0] pc_r,
    output logic flush_r,
    output logic access_block_r,
    output exc_unit_pkg::stack_wr_t stack_wr_r,
    output logic [31:0] status_word_r
);
    import exc_unit_pkg::*;

    // Elaboration check: stack indices come straight from the 7-bit frame pointer field.
    if (STACK_IDX_W != 7)
    begin : g_bad_idx_w
        $error("STACK_IDX_W must be 7 to match the frame pointer field");
    end

    // =====================================================
    // State
    exc_state_t state_r, state_nxt;
    exc_kind_t kind_r, sel_kind;
    logic [31:0] bus_control_register_r, function_control_register_r;
    logic [31:0] memory_control_register_r, upper_stack_bound_r;
    logic [31:0] save_pc_r, save_sw_r, entry_r;
    logic reset_pin_q_r, rst_pend_r, err_pend_r, xovf_pend_r, par_pend_r;
    logic [4:0] fl_eff;
    logic [6:0] frame_idx;
    logic lock, any_int, trace_due, err_now, take, boundary, enter;
    logic rst_set, err_set, xovf_set, par_set, par_enabled;
    logic [1:0] len_sel;
    logic [31:0] sw_cur, sw_saved, sw_entry;
    logic bus_acc, bus_wr;
    logic [31:0] rd_mux;
    logic rd_ok;

    // =====================================================
    // Condition capture
    // Reset exception on a rising reset pin or a watchdog overrun.
    assign rst_set = (reset_pin_n & ~reset_pin_q_r) | watchdog_overrun;
    // Pointer and frame errors are latched until the instruction completes.
    assign err_set = (mem_req & addr_zero)
        | (frame_restructure & (frame_top >= upper_stack_bound_r));
    // Only arm the overflow while it is enabled.
    assign xovf_set = xovf_event & ~function_control_register_r[`FUNC_XOVF_DIS_BIT];
    assign par_enabled = ~bus_control_register_r[`BUS_PAR_DIS_LO + 32'(parity_area)];
    assign par_set = parity_err & par_enabled;
    assign any_int = int_ext | int_timer | int_io_line_three;

    // =====================================================
    // Priority selection at an instruction boundary
    assign lock = status_word_r[`SW_LOCK_BIT];
    assign boundary = (state_r == ST_IDLE) & insn_done;
    assign err_now = range_err | priv_err | err_pend_r | err_set;
    // Trace skips delayed branches and the call itself; it resumes after the next one.
    assign trace_due = status_word_r[`SW_TRACE_BIT] & status_word_r[`SW_PEND_TRACE_BIT]
        & ~is_dbranch & ~is_call;
    // Highest priority wins, the rest stay pending or are dropped.
    assign sel_kind = rst_pend_r ? EK_RESET :
        ~insn_done ? EK_NONE :
        err_now ? EK_ERROR :
        is_trap ? EK_TRAP :
        (xovf_pend_r & ~lock) ? EK_XOVF :
        (par_pend_r & ~lock) ? EK_PARITY :
        (any_int & ~lock) ? EK_INT :
        trace_due ? EK_TRACE : EK_NONE;
    assign take = (state_r == ST_IDLE) & (sel_kind != EK_NONE);

    // Delay-slot errors point back at the delay instruction.
    // Off a boundary (reset exception) the length code of the last instruction stays.
    assign len_sel = ~insn_done ? sw_cur[`SW_LEN_HI:`SW_LEN_LO] :
        (sel_kind == EK_ERROR & in_delay_slot) ? branch_len :
        is_return ? 2'h0 : insn_len;
    assign sw_cur = sw_wr ? sw_wdata : status_word_r;

    // Status word image that is stored into the new frame.
    always_comb
    begin
        sw_saved = sw_cur;
        sw_saved[`SW_LEN_HI:`SW_LEN_LO] = len_sel;
    end

    // =====================================================
    // Frame arithmetic
    assign fl_eff = (status_word_r[`SW_FRAME_LEN_HI:`SW_FRAME_LEN_LO] == 4'h0) ?
        `FRAME_LEN_ZERO_AS : {1'b0, status_word_r[`SW_FRAME_LEN_HI:`SW_FRAME_LEN_LO]};
    assign frame_idx = status_word_r[`SW_FRAME_PTR_HI:`SW_FRAME_PTR_LO] + {2'h0, fl_eff};
    assign enter = (state_r == ST_ENTER);

    // New status word on entry; condition flags pass through untouched.
    always_comb
    begin
        sw_entry = status_word_r;
        sw_entry[`SW_FRAME_PTR_HI:`SW_FRAME_PTR_LO] = frame_idx;
        sw_entry[`SW_FRAME_LEN_HI:`SW_FRAME_LEN_LO] = (kind_r == EK_TRAP) ?
            `FRAME_LEN_TRAP : `FRAME_LEN_EXC;
        sw_entry[`SW_CACHE_BIT] = 1'b0;
        sw_entry[`SW_TRACE_BIT] = 1'b0;
        sw_entry[`SW_LOCK_BIT] = 1'b1;
        sw_entry[`SW_SUPER_BIT] = 1'b1;
        if (kind_r == EK_INT)
            sw_entry[`SW_INTMODE_BIT] = 1'b1;
    end

    // =====================================================
    // Sequencer
    always_comb
    begin
        case (state_r)
            ST_IDLE: state_nxt = take ? ST_SAVE_PC : ST_IDLE;
            ST_SAVE_PC: state_nxt = ST_SAVE_SW;
            ST_SAVE_SW: state_nxt = ST_ENTER;
            ST_ENTER: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            state_r <= ST_IDLE;
        else if (ce)
            state_r <= state_nxt;
    end

    // Capture everything the save needs when the exception is taken.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            kind_r <= EK_NONE;
            save_pc_r <= 32'h0;
            save_sw_r <= 32'h0;
            entry_r <= 32'h0;
        end
        else if (ce && take)
        begin
            kind_r <= sel_kind;
            save_pc_r <= (sel_kind == EK_ERROR & in_delay_slot) ? delay_pc : ret_pc;
            save_sw_r <= sw_saved;
            case (sel_kind)
                EK_RESET: entry_r <= `ENTRY_RESET;
                EK_ERROR: entry_r <= `ENTRY_ERROR;
                EK_TRAP: entry_r <= trap_entry;
                EK_XOVF: entry_r <= `ENTRY_XOVF;
                EK_PARITY: entry_r <= `ENTRY_PARITY;
                EK_INT: entry_r <= `ENTRY_INT;
                default: entry_r <= `ENTRY_TRACE;
            endcase
        end
    end

    // =====================================================
    // Pending conditions; a new event wins over a clear in the same cycle, except the latched error, which a boundary clears.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reset_pin_q_r <= 1'b1;
            rst_pend_r <= 1'b0;
            err_pend_r <= 1'b0;
            xovf_pend_r <= 1'b0;
            par_pend_r <= 1'b0;
        end
        else if (ce)
        begin
            reset_pin_q_r <= reset_pin_n;
            rst_pend_r <= rst_set | (rst_pend_r & ~(enter & kind_r == EK_RESET));
            // A finished instruction consumes its latched error either way.
            err_pend_r <= err_set & ~boundary | (err_pend_r & ~boundary);
            // Repeat overflows merge into the one pending trap.
            xovf_pend_r <= xovf_set | (xovf_pend_r & ~(enter & kind_r == EK_XOVF)
                & ~function_control_register_r[`FUNC_XOVF_DIS_BIT]);
            // Disabling parity checks later does not drop a saved condition.
            par_pend_r <= par_set | (par_pend_r & ~(enter & kind_r == EK_PARITY));
        end
    end

    // =====================================================
    // Status word and access blocking
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            status_word_r <= 32'h0;
            access_block_r <= 1'b0;
        end
        else if (ce)
        begin
            access_block_r <= mem_req & addr_zero;
            if (enter)
                status_word_r <= sw_entry;
            else if (boundary && !take)
                status_word_r <= sw_saved;
            else if (sw_wr && state_r == ST_IDLE)
                status_word_r <= sw_wdata;
        end
    end

    // =====================================================
    // Stack writes, program counter load, pipeline flush
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stack_wr_r <= '0;
            pc_load_r <= 1'b0;
            pc_r <= 32'h0;
            flush_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else if (ce)
        begin
            stack_wr_r.we <= (state_nxt == ST_SAVE_PC) | (state_nxt == ST_SAVE_SW);
            if (state_nxt == ST_SAVE_PC)
            begin
                stack_wr_r.idx <= frame_idx;
                stack_wr_r.data <= {(sel_kind == EK_ERROR & in_delay_slot) ? delay_pc[31:1]
                    : ret_pc[31:1], sw_cur[`SW_SUPER_BIT]};
            end
            else if (state_nxt == ST_SAVE_SW)
            begin
                stack_wr_r.idx <= frame_idx + 7'h1;
                stack_wr_r.data <= save_sw_r;
            end
            pc_load_r <= enter;
            if (enter)
                pc_r <= entry_r;
            flush_r <= enter & (kind_r == EK_RESET);
            busy_r <= (state_nxt != ST_IDLE);
        end
    end

    // =====================================================
    // Register bus slave: one wait state, error on unmapped offsets.
    assign bus_acc = apb_req.psel & apb_req.penable & ~apb_rsp.pready;
    assign bus_wr = bus_acc & apb_req.pwrite;
    always_comb
    begin
        rd_ok = 1'b1;
        case (apb_req.paddr)
            `OFF_BUS_CTRL: rd_mux = bus_control_register_r;
            `OFF_FUNC_CTRL: rd_mux = function_control_register_r;
            `OFF_MEM_CTRL: rd_mux = memory_control_register_r;
            `OFF_STACK_BOUND: rd_mux = upper_stack_bound_r;
            `OFF_STATUS: rd_mux = status_word_r;
            `OFF_PENDING: rd_mux = {28'h0, par_pend_r, xovf_pend_r, err_pend_r, busy_r};
            default:
            begin
                rd_mux = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Control registers; a reset exception overrides a control register write in that cycle, but a stack bound write still lands.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bus_control_register_r <= `CTRL_RESET_VAL;
            function_control_register_r <= `CTRL_RESET_VAL;
            memory_control_register_r <= `CTRL_RESET_VAL;
            upper_stack_bound_r <= `CTRL_RESET_VAL;
            apb_rsp <= '0;
        end
        else if (ce)
        begin
            apb_rsp.pready <= bus_acc;
            apb_rsp.pslverr <= bus_acc & ~rd_ok;
            apb_rsp.prdata <= (bus_acc & ~apb_req.pwrite) ? rd_mux : 32'h0;
            if (enter && kind_r == EK_RESET)
            begin
                bus_control_register_r <= `CTRL_RESET_VAL;
                function_control_register_r <= `CTRL_RESET_VAL;
                memory_control_register_r <= `CTRL_RESET_VAL;
            end
            else if (bus_wr)
            begin
                if (apb_req.paddr == `OFF_BUS_CTRL)
                    bus_control_register_r <= apb_req.pwdata;
                if (apb_req.paddr == `OFF_FUNC_CTRL)
                    function_control_register_r <= apb_req.pwdata;
                if (apb_req.paddr == `OFF_MEM_CTRL)
                    memory_control_register_r <= apb_req.pwdata;
            end
            if (bus_wr && apb_req.paddr == `OFF_STACK_BOUND)
                upper_stack_bound_r <= apb_req.pwdata;
        end
    end

    // =====================================================
    // Checks
    // Two stack writes, one quiet cycle, then the handler address is loaded.
    sequence s_save;
        stack_wr_r.we ##1 stack_wr_r.we ##1 !stack_wr_r.we && !pc_load_r ##1 pc_load_r;
    endsequence

    a_save_sequence: assert property (@(posedge clk) disable iff (reset || !ce)
        take |=> s_save) else $error("save sequence not two writes then load");
    a_sw_slot: assert property (@(posedge clk) disable iff (reset || !ce)
        state_r == ST_SAVE_PC |-> stack_wr_r.idx + 7'h1 == $past(frame_idx) + 7'h1
        ##1 stack_wr_r.idx == $past(stack_wr_r.idx) + 7'h1)
        else $error("status word not one above saved pc");
    a_reset_first: assert property (@(posedge clk) disable iff (reset || !ce)
        rst_pend_r && state_r == ST_IDLE |=> kind_r == EK_RESET)
        else $error("reset not given priority");
    a_reset_entry: assert property (@(posedge clk) disable iff (reset || !ce)
        enter && kind_r == EK_RESET |=> flush_r && pc_r == `ENTRY_RESET
        && function_control_register_r == `CTRL_RESET_VAL)
        else $error("reset entry incomplete");
    a_entry_flags: assert property (@(posedge clk) disable iff (reset || !ce)
        enter |=> status_word_r[`SW_SUPER_BIT] && status_word_r[`SW_LOCK_BIT]
        && !status_word_r[`SW_TRACE_BIT] && !status_word_r[`SW_CACHE_BIT]
        && status_word_r[`SW_COND_HI:0] == $past(status_word_r[`SW_COND_HI:0]))
        else $error("entry flags wrong");
    a_frame_len: assert property (@(posedge clk) disable iff (reset || !ce)
        enter |=> status_word_r[`SW_FRAME_LEN_HI:`SW_FRAME_LEN_LO]
        == (($past(kind_r) == EK_TRAP) ? 4'h6 : 4'h2))
        else $error("frame length after entry wrong");
    a_int_mode: assert property (@(posedge clk) disable iff (reset || !ce)
        enter && kind_r == EK_INT |=> status_word_r[`SW_INTMODE_BIT])
        else $error("interrupt mode flag not set");
    a_parity_hold: assert property (@(posedge clk) disable iff (reset || !ce)
        par_pend_r && !(enter && kind_r == EK_PARITY) |=> par_pend_r)
        else $error("parity condition lost");
    a_xovf_lock: assert property (@(posedge clk) disable iff (reset || !ce)
        take && lock |-> sel_kind != EK_XOVF && sel_kind != EK_PARITY && sel_kind != EK_INT)
        else $error("blocked condition taken under lock");
    a_ptr_block: assert property (@(posedge clk) disable iff (reset || !ce)
        mem_req && addr_zero |=> access_block_r)
        else $error("zero pointer access not blocked");
    a_call_trace: assert property (@(posedge clk) disable iff (reset || !ce)
        boundary && (is_call || is_dbranch) |-> sel_kind != EK_TRACE)
        else $error("trace taken after call or delayed branch");
endmodule // exc_unit

// file: design/exc_unit_params.svh
// Behaviour
// - Coincident exceptions: only highest priority, reset first.
// - Entry: load handler address, supervisor flag set.
// - Save old PC and supervisor flag at frame top.
// - Save old status word next; length zero means 16.
// - Advance frame pointer, frame length becomes two.
// - Clear cache and trace flags, set lock.
// - Trap instruction sets frame length six.
// - Reset pin rise or watchdog raises reset.
// - Reset flushes pipes, control registers all ones.
// - Range, pointer, frame, privilege share one entry.
// - Zero address register: pointer error, no access.
// - Frame reaching upper stack bound: frame error.
// - Extended overflow raised only when control bit16 zero.
// - Blocked extended overflow stays pending until unblocked.
// - Overflow pending cleared by trap or bit16.
// - Parity error traps only for enabled areas.
// - Parity pending cleared only by its trap.
// - Interrupt sets interrupt-mode flag; lock blocks more.
// - Trace after each non-delayed-branch when enabled, pending.
// - Call suppresses trace for one instruction.
// - Delay-slot errors save delay address, branch length.
// - Otherwise return address, last length; return clears.
`ifndef EXC_UNIT_PARAMS_SVH
`define EXC_UNIT_PARAMS_SVH
// =====================================================
// Register offsets (byte addresses on the register bus)
`define OFF_BUS_CTRL 12'h000
`define OFF_FUNC_CTRL 12'h004
`define OFF_MEM_CTRL 12'h008
`define OFF_STACK_BOUND 12'h00c
`define OFF_STATUS 12'h010
`define OFF_PENDING 12'h014
`define CTRL_RESET_VAL 32'hffffffff
// =====================================================
// Status word field positions
`define SW_COND_HI 3
`define SW_CACHE_BIT 4
`define SW_TRACE_BIT 5
`define SW_INTMODE_BIT 7
`define SW_PEND_TRACE_BIT 8
`define SW_LOCK_BIT 15
`define SW_SUPER_BIT 18
`define SW_LEN_LO 19
`define SW_LEN_HI 20
`define SW_FRAME_LEN_LO 21
`define SW_FRAME_LEN_HI 24
`define SW_FRAME_PTR_LO 25
`define SW_FRAME_PTR_HI 31
`define FUNC_XOVF_DIS_BIT 16
`define BUS_PAR_DIS_LO 28
// =====================================================
// Frame lengths and handler entry addresses
`define FRAME_LEN_EXC 4'h2
`define FRAME_LEN_TRAP 4'h6
`define FRAME_LEN_ZERO_AS 5'h10
`define ENTRY_RESET 32'hfffffff8
`define ENTRY_ERROR 32'hfffffff0
`define ENTRY_XOVF 32'hffffffe8
`define ENTRY_PARITY 32'hffffffe0
`define ENTRY_INT 32'hffffffd8
`define ENTRY_TRACE 32'hffffffd0
`endif

// file: design/exc_unit_pkg.sv
package exc_unit_pkg;
    // Kind of exception being processed.
    typedef enum logic [2:0] {EK_NONE, EK_RESET, EK_ERROR, EK_TRAP, EK_XOVF, EK_PARITY,
        EK_INT, EK_TRACE} exc_kind_t;
    typedef enum {ST_IDLE, ST_SAVE_PC, ST_SAVE_SW, ST_ENTER} exc_state_t;
    // Register bus request and answer.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
    // One write into the register stack.
    typedef struct packed {
        logic we;
        logic [6:0] idx;
        logic [31:0] data;
    } stack_wr_t;
endpackage

// file: tb/pipe_stack_model.sv
`timescale 1ns/1ns
// ====================
// Pipeline and register stack seen from the exception unit.
module pipe_stack_model
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Bench request, unit stall and stack write.
    input wire logic step,
    input wire logic busy_r,
    input wire exc_unit_pkg::stack_wr_t stack_wr_r,
    output logic insn_done
);
    import exc_unit_pkg::*;
    logic pend_r;
    logic go;
    logic [31:0] mem [0:127];
    // A finished instruction waits while the unit is busy, as a real pipeline stalls.
    assign go = (pend_r | step) & ~busy_r & ~insn_done;
    // Stack writes land as the unit issues them; a late write would corrupt a frame.
    always_ff @(posedge clk)
    begin
        pend_r <= ~reset & (pend_r | step) & ~go;
        insn_done <= ~reset & go;
        if (stack_wr_r.we)
            mem[stack_wr_r.idx] <= stack_wr_r.data;
    end
endmodule // pipe_stack_model

// file: tb/test_exc_unit.sv
`timescale 1ns/1ns
`include "exc_unit_params.svh"
// ====================
// Self-checking bench for the exception sequencer.
module test_exc_unit;
    import exc_unit_pkg::*;
    logic clk, reset, ce, step, insn_done, is_call, is_return, is_dbranch, is_trap, e;
    logic in_delay_slot, range_err, priv_err, sw_wr, mem_req, addr_zero, frame_restructure;
    logic xovf_event, parity_err, int_ext, int_timer, int_io_line_three, reset_pin_n;
    logic watchdog_overrun, busy_r, pc_load_r, flush_r, access_block_r;
    logic [1:0] insn_len, branch_len, parity_area;
    logic [31:0] trap_entry, ret_pc, delay_pc, sw_wdata, frame_top, pc_r, status_word_r, o, q;
    apb_req_t apb_req;
    apb_rsp_t apb_rsp;
    stack_wr_t stack_wr_r;
    int seed = 15124;
    int miscompares = 0;
    int num_checks = 0;
    int loads = 0;
    int cyc = 0;
    exc_unit dut_u (.clk, .reset, .ce, .apb_req, .apb_rsp, .insn_done, .insn_len, .is_call,
        .is_return, .is_dbranch, .is_trap, .trap_entry, .ret_pc, .delay_pc, .in_delay_slot,
        .branch_len, .range_err, .priv_err, .sw_wr, .sw_wdata, .mem_req, .addr_zero,
        .frame_restructure, .frame_top, .xovf_event, .parity_err, .parity_area, .int_ext,
        .int_timer, .int_io_line_three, .reset_pin_n, .watchdog_overrun, .busy_r, .pc_load_r,
        .pc_r, .flush_r, .access_block_r, .stack_wr_r, .status_word_r);
    pipe_stack_model model_u (.clk, .reset, .step, .busy_r, .stack_wr_r, .insn_done);
    // ====================
    // Clock, handler-entry count and hang guard.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (pc_load_r === 1'b1)
            loads <= loads + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            end_sim();
        end
    end
    // ====================
    // Tasks.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // The request is held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        // No local limit: if pready never rises, only the bench timeout ends this wait.
        do
            @(posedge clk);
        while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge clk);
    endtask
    task automatic clr();
        {is_call, is_return, is_trap, in_delay_slot, range_err, priv_err, sw_wr, step} <= '0;
        {mem_req, addr_zero, frame_restructure, xovf_event, parity_err, int_ext} <= '0;
        {int_timer, int_io_line_three, watchdog_overrun, reset_pin_n, is_dbranch} <= 5'b00010;
        @(posedge clk);
    endtask
    // Loads a random status word with chosen lock, frame length zero and trace bits.
    task automatic mk(input logic l, input logic z, input logic t);
        o = $random(seed);
        {o[15], o[8], o[5]} = {l, t, t};
        if (z)
            o[24:21] = 4'h0;
        ret_pc <= $random(seed);
        insn_len <= 2'($random(seed));
        sw_wr <= 1'b1;
        sw_wdata <= o;
        @(posedge clk);
        sw_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic go();
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
    endtask
    task automatic none();
        int b;
        b = loads;
        go();
        repeat (8) @(posedge clk);
        chk(loads, b);
        clr();
    endtask
    // Expected frame save and new status word follow from the old status word o.
    task automatic take(input logic [31:0] ent, input logic [3:0] fl, input logic i,
        input logic [1:0] ln, input logic [31:0] pc, input logic rst);
        int n;
        logic [6:0] ix;
        logic [31:0] s;
        ix = o[31:25] + ((o[24:21] == 4'h0) ? 7'h10 : {3'h0, o[24:21]});
        n = 0;
        while (pc_load_r !== 1'b1 && n < 30)
        begin
            @(posedge clk);
            n++;
        end
        chk(pc_r, ent);
        chk({31'h0, flush_r}, {31'h0, rst});
        s = o;
        s[20:19] = ln;
        chk(model_u.mem[ix], {pc[31:1], o[18]});
        chk(model_u.mem[ix + 7'h1], s);
        s[31:25] = ix;
        s[24:21] = fl;
        {s[4], s[5], s[15], s[18]} = 4'b0011;
        s[7] = s[7] | i;
        chk(status_word_r & 32'hffe7ffff, s & 32'hffe7ffff);
        clr();
    endtask
    // ====================
    // Main sequence.
    initial
    begin
        {is_call, is_return, is_dbranch, is_trap, in_delay_slot, range_err, priv_err} = '0;
        {sw_wr, mem_req, addr_zero, frame_restructure, xovf_event, parity_err, int_ext} = '0;
        {int_timer, int_io_line_three, watchdog_overrun, step, apb_req} = '0;
        {sw_wdata, frame_top, trap_entry, delay_pc, ret_pc, insn_len, branch_len} = '0;
        parity_area = 2'h0;
        {ce, reset, reset_pin_n} = 3'b111;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b0, 12'(k * 4), 32'h0);
            chk(q, 32'hffffffff);
        end
        apb(1'b0, 12'h018, 32'h0);
        chk({31'h0, e}, 32'h1);
        // A status word write while the clock enable is low must not land.
        ce <= 1'b0;
        mk(1'b0, 1'b0, 1'b0);
        ce <= 1'b1;
        chk(status_word_r, 32'h0);
        mk(1'b0, 1'b0, 1'b0);
        xovf_event <= 1'b1;
        none();
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h00c, 32'h100);
        // Each error kind goes to the shared entry; a frame top equal to the bound counts.
        for (int k = 0; k < 4; k++)
        begin
            mk(1'($random(seed)), k == 0, 1'b0);
            case (k)
                0: range_err <= 1'b1;
                1: priv_err <= 1'b1;
                2: {mem_req, addr_zero} <= 2'b11;
                default: {frame_restructure, frame_top} <= {1'b1, 32'h100};
            endcase
            @(posedge clk);
            @(posedge clk);
            chk({31'h0, access_block_r}, {31'h0, k == 2});
            {mem_req, frame_restructure} <= 2'b00;
            go();
            take(`ENTRY_ERROR, 4'h2, 1'b0, insn_len, ret_pc, 1'b0);
        end
        mk(1'b0, 1'b0, 1'b0);
        {is_trap, int_ext} <= 2'b11;
        trap_entry <= $random(seed);
        go();
        take(trap_entry, 4'h6, 1'b0, insn_len, ret_pc, 1'b0);
        mk(1'b0, 1'b0, 1'b0);
        {range_err, is_trap, int_ext} <= 3'b111;
        go();
        take(`ENTRY_ERROR, 4'h2, 1'b0, insn_len, ret_pc, 1'b0);
        // Every interrupt source, first while locked out, then accepted.
        for (int k = 0; k < 3; k++)
        begin
            mk(1'b1, 1'b0, 1'b0);
            {int_io_line_three, int_timer, int_ext} <= 3'b001 << k;
            none();
            mk(1'b0, 1'b0, 1'b0);
            {int_io_line_three, int_timer, int_ext} <= 3'b001 << k;
            is_return <= (k == 0);
            go();
            take(`ENTRY_INT, 4'h2, 1'b1, (k == 0) ? 2'h0 : insn_len, ret_pc, 1'b0);
        end
        mk(1'b1, 1'b0, 1'b0);
        xovf_event <= 1'b1;
        none();
        apb(1'b0, 12'h014, 32'h0);
        chk(q, 32'h4);
        mk(1'b0, 1'b0, 1'b0);
        go();
        take(`ENTRY_XOVF, 4'h2, 1'b0, insn_len, ret_pc, 1'b0);
        mk(1'b0, 1'b0, 1'b0);
        none();
        mk(1'b0, 1'b0, 1'b0);
        {parity_err, parity_area} <= 3'b110;
        none();
        apb(1'b1, 12'h000, 32'h0);
        mk(1'b1, 1'b0, 1'b0);
        {parity_err, parity_area} <= 3'b101;
        none();
        apb(1'b1, 12'h000, 32'hf0000000);
        mk(1'b0, 1'b0, 1'b0);
        go();
        take(`ENTRY_PARITY, 4'h2, 1'b0, insn_len, ret_pc, 1'b0);
        mk(1'b0, 1'b0, 1'b0);
        {range_err, in_delay_slot, branch_len} <= 4'b1110;
        delay_pc <= $random(seed);
        go();
        take(`ENTRY_ERROR, 4'h2, 1'b0, 2'h2, delay_pc, 1'b0);
        mk(1'b0, 1'b0, 1'b1);
        is_call <= 1'b1;
        none();
        is_dbranch <= 1'b1;
        none();
        go();
        take(`ENTRY_TRACE, 4'h2, 1'b0, insn_len, ret_pc, 1'b0);
        // Reset exception from the pin's rising edge and from the watchdog.
        for (int k = 0; k < 2; k++)
        begin
            mk(1'b0, 1'b0, 1'b0);
            {reset_pin_n, watchdog_overrun} <= k ? 2'b11 : 2'b00;
            @(posedge clk);
            {reset_pin_n, watchdog_overrun} <= 2'b10;
            take(`ENTRY_RESET, 4'h2, 1'b0, o[20:19], ret_pc, 1'b1);
        end
        apb(1'b0, 12'h000, 32'h0);
        chk(q, 32'hffffffff);
        end_sim();
    end
endmodule // test_exc_unit
